// ==== hw/sppxu_pkg.sv ====
// Shared constants and carrier types for the pack, pick and widen datapath.
package sppxu_pkg;
  localparam int          DATA_W     = 32;
  localparam int          HALF_W     = 16;
  localparam int          MAJ_HI     = 31;
  localparam int          MAJ_LO     = 26;
  localparam int          FSRC_HI    = 25;
  localparam int          FSRC_LO    = 21;
  localparam int          SSRC_HI    = 20;
  localparam int          SSRC_LO    = 16;
  localparam int          RD_HI      = 15;
  localparam int          RD_LO      = 11;
  localparam int          MIN_HI     = 10;
  localparam int          MIN_LO     = 6;
  localparam int          FN_HI      = 5;
  localparam int          FN_LO      = 0;
  localparam int          CC_B3      = 27;
  localparam int          CC_B2      = 26;
  localparam int          CC_B1      = 25;
  localparam int          CC_B0      = 24;
  localparam logic [5:0]  MAJ_EXT    = 6'h1F;
  localparam logic [5:0]  FN_CMPSEL  = 6'h11;
  localparam logic [5:0]  FN_WIDEN   = 6'h12;
  localparam logic [4:0]  MIN_PICKB  = 5'h03;
  localparam logic [4:0]  MIN_PICKH  = 5'h0B;
  localparam logic [4:0]  MIN_WIDL   = 5'h0C;
  localparam logic [4:0]  MIN_WIDR   = 5'h0D;
  localparam logic [4:0]  FSRC_ZERO  = 5'h00;
  localparam logic [5:0]  PACK_FN_DEF  = 6'h11;
  localparam logic [4:0]  PACK_MIN_DEF = 5'h0E;
  localparam logic [31:0] DATA_RST   = 32'h0000_0000;
  localparam logic [4:0]  REG_RST    = 5'h00;

  typedef enum logic [2:0] {
    OP_NONE, OP_PACK, OP_PICKB, OP_PICKH, OP_WIDL, OP_WIDR
  } sppxu_op_t;

  typedef enum logic {
    PR_IDLE, PR_WAIT
  } sppxu_prd_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] instr;
    logic [31:0] src_a;
    logic [31:0] src_b;
  } sppxu_issue_t;

  typedef struct packed {
    logic        valid;
    logic [4:0]  dest;
    logic [31:0] data;
  } sppxu_res_t;
endpackage : sppxu_pkg

// ==== hw/sppxu_unit.sv ====
// Pack, condition pick and Q15 widen datapath with product read interlock.
// Functional notes
// - Pack first-source low over second-source high halfword.
// - Byte pick uses condition bits 27 to 24.
// - Condition one picks first source, else second.
// - Halfword pick uses condition bits 25 and 24.
// - Left widen: upper halfword, sixteen zero bits below.
// - Right widen: lower halfword shifted up, minor 01101.
// - Byte pick decoded by major, function, minor.
// - Halfword pick decoded by minor 01011, function 010001.
// - Left widen decoded with first source zero.
// - Right widen differs from left by minor only.
// - Only absent or disabled extension raise exceptions.
// - Malformed vector operands are not checked.
// - Product register read stalls during outstanding multiply.
`timescale 1ns/1ps
module sppxu_unit #(
  parameter logic [5:0] PACK_FN  = sppxu_pkg::PACK_FN_DEF,
  parameter logic [4:0] PACK_MIN = sppxu_pkg::PACK_MIN_DEF
) (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire sppxu_pkg::sppxu_issue_t issue,
  input  wire logic [31:0]             vector_extension_control_reg,
  input  wire logic                    ext_present,
  input  wire logic                    ext_enabled,
  input  wire logic                    mul_start,
  input  wire logic                    mul_done,
  input  wire logic                    prod_rd_req,
  output sppxu_pkg::sppxu_res_t        res_r,
  output logic                         exc_reserved_r,
  output logic                         exc_disabled_r,
  output logic                         prod_stall_r,
  output logic                         prod_rd_go_r
);
  import sppxu_pkg::*;

  logic       rst_s1_r;
  logic       rst_n_r;
  sppxu_op_t  op;
  sppxu_res_t res_nxt;
  logic       exc_reserved_nxt;
  logic       exc_disabled_nxt;
  logic       mul_busy_r;
  logic       mul_busy_nxt;
  sppxu_prd_t prd_r;
  sppxu_prd_t prd_nxt;
  logic       prod_stall_nxt;
  logic       prod_rd_go_nxt;
  logic [3:0] cc_byte;
  logic [3:0] cc_half;

  // Reset is released through two flip-flops.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // Classifies an instruction word; unrelated words give no operation.
  function automatic sppxu_op_t decode(input logic [31:0] iw);
    logic [5:0] fn;
    logic [4:0] mn;
    fn = iw[FN_HI:FN_LO];
    mn = iw[MIN_HI:MIN_LO];
    decode = OP_NONE;
    if (iw[MAJ_HI:MAJ_LO] == MAJ_EXT) begin
      if (fn == PACK_FN && mn == PACK_MIN) begin
        decode = OP_PACK;
      end else if (fn == FN_CMPSEL && mn == MIN_PICKB) begin
        decode = OP_PICKB;
      end else if (fn == FN_CMPSEL && mn == MIN_PICKH) begin
        decode = OP_PICKH;
      end else if (fn == FN_WIDEN && mn == MIN_WIDL && iw[FSRC_HI:FSRC_LO] == FSRC_ZERO) begin
        decode = OP_WIDL;
      end else if (fn == FN_WIDEN && mn == MIN_WIDR && iw[FSRC_HI:FSRC_LO] == FSRC_ZERO) begin
        decode = OP_WIDR;
      end
    end
  endfunction : decode

  // Chooses each byte from the first source when its mask bit is set.
  function automatic logic [31:0] pick_bytes(input logic [3:0] m,
                                             input logic [31:0] a,
                                             input logic [31:0] b);
    pick_bytes = b;
    for (int i = 0; i < 4; i++) begin
      if (m[i]) begin
        pick_bytes[i*8 +: 8] = a[i*8 +: 8];
      end
    end
  endfunction : pick_bytes

  assign op      = decode(issue.instr);
  assign cc_byte = vector_extension_control_reg[CC_B3:CC_B0];
  assign cc_half = {{2{vector_extension_control_reg[CC_B1]}},
                    {2{vector_extension_control_reg[CC_B0]}}};

  // Operands are used as given; no format checking is done.
  always_comb begin
    res_nxt          = '0;
    exc_reserved_nxt = 1'b0;
    exc_disabled_nxt = 1'b0;
    res_nxt.dest     = issue.instr[RD_HI:RD_LO];
    if (issue.valid && op != OP_NONE) begin
      if (!ext_present) begin
        exc_reserved_nxt = 1'b1;
      end else if (!ext_enabled) begin
        exc_disabled_nxt = 1'b1;
      end else begin
        res_nxt.valid = 1'b1;
        case (op)
          OP_PACK: begin
            res_nxt.data = {issue.src_a[HALF_W-1:0], issue.src_b[DATA_W-1:HALF_W]};
          end
          OP_PICKB: begin
            res_nxt.data = pick_bytes(cc_byte, issue.src_a, issue.src_b);
          end
          OP_PICKH: begin
            res_nxt.data = pick_bytes(cc_half, issue.src_a, issue.src_b);
          end
          OP_WIDL: begin
            res_nxt.data = {issue.src_b[DATA_W-1:HALF_W], {HALF_W{1'b0}}};
          end
          OP_WIDR: begin
            res_nxt.data = {issue.src_b[HALF_W-1:0], {HALF_W{1'b0}}};
          end
          default: begin
            res_nxt.valid = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      res_r          <= '{valid: 1'b0, dest: REG_RST, data: DATA_RST};
      exc_reserved_r <= 1'b0;
      exc_disabled_r <= 1'b0;
    end else begin
      res_r          <= res_nxt;
      exc_reserved_r <= exc_reserved_nxt;
      exc_disabled_r <= exc_disabled_nxt;
    end
  end

  // Product register read interlock; a new multiply start wins over done.
  always_comb begin
    mul_busy_nxt   = mul_start | (mul_busy_r & ~mul_done);
    prd_nxt        = prd_r;
    prod_stall_nxt = 1'b0;
    prod_rd_go_nxt = 1'b0;
    case (prd_r)
      PR_IDLE: begin
        if (prod_rd_req) begin
          if (mul_busy_r && !mul_done) begin
            prd_nxt        = PR_WAIT;
            prod_stall_nxt = 1'b1;
          end else begin
            prod_rd_go_nxt = 1'b1;
          end
        end
      end
      PR_WAIT: begin
        if (mul_done) begin
          prd_nxt        = PR_IDLE;
          prod_rd_go_nxt = 1'b1;
        end else begin
          prod_stall_nxt = 1'b1;
        end
      end
      default: begin
        prd_nxt = PR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      mul_busy_r   <= 1'b0;
      prd_r        <= PR_IDLE;
      prod_stall_r <= 1'b0;
      prod_rd_go_r <= 1'b0;
    end else begin
      mul_busy_r   <= mul_busy_nxt;
      prd_r        <= prd_nxt;
      prod_stall_r <= prod_stall_nxt;
      prod_rd_go_r <= prod_rd_go_nxt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n_r);

  logic ok_r;
  assign ok_r = issue.valid && ext_present && ext_enabled;

  pack_result_a: assert property (ok_r && op == OP_PACK |=> res_r.valid &&
    res_r.data == {$past(issue.src_a[15:0]), $past(issue.src_b[31:16])})
    else $error("pack result wrong");
  byte_pick_a: assert property (ok_r && op == OP_PICKB |=>
    res_r.data[31:24] == ($past(vector_extension_control_reg[27]) ?
      $past(issue.src_a[31:24]) : $past(issue.src_b[31:24])) &&
    res_r.data[23:16] == ($past(vector_extension_control_reg[26]) ?
      $past(issue.src_a[23:16]) : $past(issue.src_b[23:16])) &&
    res_r.data[15:8] == ($past(vector_extension_control_reg[25]) ?
      $past(issue.src_a[15:8]) : $past(issue.src_b[15:8])) &&
    res_r.data[7:0] == ($past(vector_extension_control_reg[24]) ?
      $past(issue.src_a[7:0]) : $past(issue.src_b[7:0])))
    else $error("byte pick wrong");
  pick_all_one_a: assert property (ok_r && op == OP_PICKB &&
    vector_extension_control_reg[27:24] == 4'hF |=> res_r.data == $past(issue.src_a))
    else $error("set condition must select first source");
  half_pick_a: assert property (ok_r && op == OP_PICKH |=>
    res_r.data[31:16] == ($past(vector_extension_control_reg[25]) ?
      $past(issue.src_a[31:16]) : $past(issue.src_b[31:16])) &&
    res_r.data[15:0] == ($past(vector_extension_control_reg[24]) ?
      $past(issue.src_a[15:0]) : $past(issue.src_b[15:0])))
    else $error("halfword pick wrong");
  widen_left_a: assert property (ok_r && op == OP_WIDL |=>
    res_r.data == {$past(issue.src_b[31:16]), 16'h0000})
    else $error("left widen wrong");
  widen_right_a: assert property (ok_r && op == OP_WIDR |=>
    res_r.data == {$past(issue.src_b[15:0]), 16'h0000})
    else $error("right widen wrong");
  decode_pickb_a: assert property (issue.instr[31:26] == 6'h1F &&
    issue.instr[5:0] == 6'h11 && issue.instr[10:6] == 5'h03 |-> op == OP_PICKB)
    else $error("byte pick not decoded");
  decode_pickh_a: assert property (issue.instr[31:26] == 6'h1F &&
    issue.instr[5:0] == 6'h11 && issue.instr[10:6] == 5'h0B |-> op == OP_PICKH)
    else $error("halfword pick not decoded");
  widen_src_a: assert property (issue.instr[25:21] != 5'h00 |->
    op != OP_WIDL && op != OP_WIDR)
    else $error("widen with nonzero first source decoded");
  exc_only_a: assert property (issue.valid && op != OP_NONE && ext_present && ext_enabled
    |=> !exc_reserved_r && !exc_disabled_r)
    else $error("exception without cause");
  exc_absent_a: assert property (issue.valid && op != OP_NONE && !ext_present
    |=> exc_reserved_r && !res_r.valid)
    else $error("absent extension not reported");
  stall_hold_a: assert property (prod_rd_req && mul_busy_r && !mul_done && prd_r == PR_IDLE
    |=> prod_stall_r && !prod_rd_go_r)
    else $error("product read not stalled");
  stall_release_a: assert property (prd_r == PR_WAIT && mul_done |=>
    prod_rd_go_r && !prod_stall_r)
    else $error("stall not released");

  pack_seen_c: cover property (ok_r && op == OP_PACK);
  pickh_seen_c: cover property (ok_r && op == OP_PICKH);
  stall_seen_c: cover property (prod_stall_r ##1 prod_rd_go_r);
  disabled_seen_c: cover property (exc_disabled_r);
endmodule : sppxu_unit

// ==== tb/sppxu_mul_model.sv ====
// Multiply unit model that starts a product and reports it written after a set latency.
`timescale 1ns/1ps
module sppxu_mul_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       launch,
  input  wire logic [7:0] latency,
  output logic            mul_start,
  output logic            mul_done
);
  logic [7:0] cnt_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r     <= 8'h00;
      mul_start <= 1'b0;
      mul_done  <= 1'b0;
    end else begin
      mul_start <= launch;
      mul_done  <= (cnt_r == 8'h01);
      if (launch) begin
        cnt_r <= latency;
      end else if (cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end
endmodule : sppxu_mul_model

// ==== tb/simd_pack_pick_expand_unit_tb.sv ====
// Self-checking bench for the pack, pick and widen datapath.
`timescale 1ns/1ps
module simd_pack_pick_expand_unit_tb;
  import sppxu_pkg::*;
  localparam logic [7:0]  LAT = 8'h05;
  localparam logic [31:0] SA  = 32'h1122_3344;
  localparam logic [31:0] SB  = 32'hAABB_CCDD;
  logic         clk = 1'b0;
  logic         rst_n, ext_present, ext_enabled, prod_rd_req, launch, mul_start, mul_done;
  logic [31:0]  vector_extension_control_reg, e;
  sppxu_issue_t issue;
  sppxu_res_t   res_r;
  logic         exc_reserved_r, exc_disabled_r, prod_stall_r, prod_rd_go_r;
  int           n_fail, n_compared, cycles, n;

  sppxu_unit i_dut (.clk(clk), .rst_n(rst_n), .issue(issue),
    .vector_extension_control_reg(vector_extension_control_reg),
    .ext_present(ext_present), .ext_enabled(ext_enabled), .mul_start(mul_start),
    .mul_done(mul_done), .prod_rd_req(prod_rd_req), .res_r(res_r),
    .exc_reserved_r(exc_reserved_r), .exc_disabled_r(exc_disabled_r),
    .prod_stall_r(prod_stall_r), .prod_rd_go_r(prod_rd_go_r));
  sppxu_mul_model i_mul (.clk(clk), .rst_n(rst_n), .launch(launch), .latency(LAT),
    .mul_start(mul_start), .mul_done(mul_done));

  always #25 clk = ~clk;

  task summarize;
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      summarize();
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [31:0] enc(input logic [4:0] fs, input logic [4:0] mn,
                                      input logic [5:0] fn);
    return {MAJ_EXT, fs, 5'h02, 5'h15, mn, fn};
  endfunction : enc

  // Issues one word and checks the answer 1 ns after the taking edge.
  task op(input logic [31:0] ins, input logic [31:0] ctl, input logic ev, input logic er,
          input logic ed, input logic [31:0] ed_data);
    @(posedge clk);
    issue                        <= '{1'b1, ins, SA, SB};
    vector_extension_control_reg <= ctl;
    @(posedge clk);
    issue                        <= '{1'b0, ins, SA, SB};
    #1;
    chk({29'h0, res_r.valid, exc_reserved_r, exc_disabled_r}, {29'h0, ev, er, ed});
    if (ev) begin
      chk(res_r.data, ed_data);
      chk({27'h0, res_r.dest}, 32'h15);
    end
  endtask : op

  initial begin
    rst_n = 1'b0;
    ext_present = 1'b1;
    ext_enabled = 1'b1;
    prod_rd_req = 1'b0;
    launch = 1'b0;
    vector_extension_control_reg = 32'h0;
    issue = '0;
    n_fail = 0;
    n_compared = 0;
    cycles = 0;
    repeat (8) @(posedge clk);
    #1 chk({28'h0, res_r.valid, exc_reserved_r, prod_stall_r, prod_rd_go_r}, 32'h0);
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    op(enc(5'h03, PACK_MIN_DEF, PACK_FN_DEF), 32'h0, 1, 0, 0, 32'h3344_AABB);
    for (int c = 0; c < 16; c++) begin
      for (int k = 0; k < 4; k++) e[8*k+:8] = c[k] ? SA[8*k+:8] : SB[8*k+:8];
      op(enc(5'h03, MIN_PICKB, FN_CMPSEL), {4'hA, c[3:0], 24'hFFFFFF}, 1, 0, 0, e);
    end
    for (int c = 0; c < 4; c++) begin
      e = {c[1] ? SA[31:16] : SB[31:16], c[0] ? SA[15:0] : SB[15:0]};
      op(enc(5'h03, MIN_PICKH, FN_CMPSEL), {4'h0, ~c[1:0], c[1:0], 24'h0}, 1, 0, 0, e);
    end
    op(enc(5'h00, MIN_WIDL, FN_WIDEN), 32'h0, 1, 0, 0, 32'hAABB_0000);
    op(enc(5'h00, MIN_WIDR, FN_WIDEN), 32'h0, 1, 0, 0, 32'hCCDD_0000);
    op(enc(5'h04, MIN_WIDL, FN_WIDEN), 32'h0, 0, 0, 0, 32'h0);
    op(enc(5'h03, MIN_PICKH, FN_WIDEN), 32'h0, 0, 0, 0, 32'h0);
    op(enc(5'h03, MIN_PICKB, FN_CMPSEL) ^ 32'h8000_0000, 32'h0, 0, 0, 0, 32'h0);
    @(posedge clk) ext_enabled <= 1'b0;
    op(enc(5'h03, MIN_PICKB, FN_CMPSEL), 32'h0, 0, 0, 1, 32'h0);
    @(posedge clk) ext_present <= 1'b0;
    op(enc(5'h00, MIN_WIDR, FN_WIDEN), 32'h0, 0, 1, 0, 32'h0);
    @(posedge clk) ext_enabled <= 1'b1;
    op(enc(5'h03, PACK_MIN_DEF, PACK_FN_DEF), 32'h0, 0, 1, 0, 32'h0);
    @(posedge clk) prod_rd_req <= 1'b1;
    @(posedge clk) prod_rd_req <= 1'b0;
    #1 chk({30'h0, prod_stall_r, prod_rd_go_r}, 32'h1);
    @(posedge clk) launch <= 1'b1;
    @(posedge clk) launch <= 1'b0;
    @(posedge clk) prod_rd_req <= 1'b1;
    @(posedge clk) prod_rd_req <= 1'b0;
    #1 chk({30'h0, prod_stall_r, prod_rd_go_r}, 32'h2);
    n = 0;
    while (prod_rd_go_r !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n, LAT - 8'h01);
    chk({30'h0, prod_stall_r, prod_rd_go_r}, 32'h1);
    repeat (2) @(posedge clk);
    summarize();
  end
endmodule : simd_pack_pick_expand_unit_tb
